// ### hdl/rbx_core.sv
// Relative branch and bit-set execution unit
// Operation
// - Carry-clear branch taken only with carry zero
// - Not-negative branch taken only with negative zero
// - No-overflow branch taken only with overflow zero
// - Nonzero branch taken only with zero zero
// - Signed 8-bit offset doubled before adding
// - Taken target is incremented counter plus 2n
// - One word; one cycle, two when taken
// - Always-branch uses 11-bit offset, two cycles
// - Access bit selects access bank or bank register
`timescale 1ns/100ps
module rbx_core
   import rbx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire rbx_flags_s flags,
   input wire logic [3:0] bank_select_register,
   output logic [PC_W-1:0] pc,
   output logic busy,
   output logic branch_taken,
   output rbx_flags_s flags_out
);
   // Execution state: fetch/execute, forced idle cycle or bit-set write-back cycle
   typedef enum logic [2:0]
   {
      ST_EXEC = 3'h1,
      ST_FLUSH = 3'h2,
      ST_WRITE = 3'h4
   } rbx_state_e;

   rbx_state_e state; // Current state
   logic [PC_W-1:0] pc_inc; // Counter already moved past this word
   logic [PC_W-1:0] ofs_short; // Doubled 8-bit offset
   logic [PC_W-1:0] ofs_long; // Doubled 11-bit offset
   logic [PC_W-1:0] next_pc; // Target of a taken branch
   logic cond_hit; // Conditional branch condition met
   logic is_long; // Unconditional branch decoded
   logic is_set; // Bit-set decoded
   logic take; // Any branch taken this cycle
   logic [11:0] file_addr; // Banked file address
   logic [11:0] set_addr; // Address held for write-back
   logic [2:0] set_bit; // Bit held for write-back
   logic [7:0] rd_data; // Memory read data
   rbx_wr_s wr; // Write-back request
   logic [OFS_BR_W-1:0] long_field; // Raw long offset

   assign pc_inc = pc + PC_STEP;
   // Sign-extend then double the short offset
   assign ofs_short = {{(PC_W-OPC_LO-1){instr[OPC_LO-1]}}, instr[OPC_LO-1:0], 1'b0};
   assign long_field = instr[OFS_BR_W-1:0];
   assign ofs_long = {{(PC_W-12){long_field[OFS_BR_W-1]}}, long_field, 1'b0};
   assign is_long = instr[OPC_HI:OFS_BR_W] == OP_BR_ALWAYS;
   assign is_set = instr[OPC_HI:BIT_HI+1] == OP_SET_BIT;

   // Decode conditional branches; each tests a cleared flag
   always_comb
   begin
      case (instr[OPC_HI:OPC_LO])
         OP_BR_CARRY_CLR: cond_hit = !flags.carry;
         OP_BR_NOT_NEG: cond_hit = !flags.negative;
         OP_BR_NO_OVF: cond_hit = !flags.overflow;
         OP_BR_NONZERO: cond_hit = !flags.zero;
         default: cond_hit = 1'b0;
      endcase
   end

   assign take = instr_valid && (state == ST_EXEC) && (cond_hit || is_long);
   assign next_pc = pc_inc + (is_long ? ofs_long : ofs_short);

   // Access bank versus banked file addressing
   always_comb
   begin
      if (!instr[ACC_POS])
      begin
         // Access bank: bank 0 below ACC_SPLIT (0x60), bank 15 from 0x60 up
         file_addr = {(instr[OPC_LO-1:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, instr[OPC_LO-1:0]};
      end
      else
      begin
         file_addr = {bank_select_register, instr[OPC_LO-1:0]};
      end
   end

   // Program counter: step one word, or jump when taken
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pc <= '0;
      end
      else if (take)
      begin
         pc <= next_pc;
      end
      else if (instr_valid && state == ST_EXEC)
      begin
         pc <= pc_inc;
      end
   end

   // State: a taken branch spends a second, idle cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_EXEC;
      end
      else
      begin
         case (state)
            ST_EXEC:
            begin
               if (take)
               begin
                  state <= ST_FLUSH;
               end
               else if (instr_valid && is_set)
               begin
                  state <= ST_WRITE;
               end
            end
            ST_FLUSH: state <= ST_EXEC;
            ST_WRITE: state <= ST_EXEC;
            default: state <= ST_EXEC;
         endcase
      end
   end

   // Hold address and bit for the bit-set write-back
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         set_addr <= '0;
         set_bit <= '0;
      end
      else if (instr_valid && state == ST_EXEC && is_set)
      begin
         set_addr <= file_addr;
         set_bit <= instr[BIT_HI:BIT_LO];
      end
   end

   // Write-back merges the chosen bit into the read byte;
   // memory latency splits read and write over two clocks of one instruction
   always_comb
   begin
      wr.en = (state == ST_WRITE);
      wr.addr = set_addr;
      wr.data = rd_data | (8'h01 << set_bit);
   end

   rbx_file_ram u_ram
   (
      .ref_clk(ref_clk),
      .rd_addr(file_addr),
      .rd_data(rd_data),
      .wr(wr)
   );

   // Status outputs; flags pass unchanged for every instruction here
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         busy <= 1'b0;
         branch_taken <= 1'b0;
         flags_out <= '0;
      end
      else
      begin
         busy <= take || (instr_valid && state == ST_EXEC && is_set);
         branch_taken <= take;
         flags_out <= flags;
      end
   end

   // Taken branch: target, then an idle cycle
   sequence taken_s;
      take ##1 (state == ST_FLUSH);
   endsequence

   branch_target_a: assert property (@(posedge ref_clk) disable iff (reset)
      take |=> pc == $past(next_pc))
      else $error("branch target wrong");
   flush_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
      take |=> (state == ST_FLUSH) ##1 (state == ST_EXEC))
      else $error("taken branch not two cycles");
   carry_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && instr[OPC_HI:OPC_LO] == OP_BR_CARRY_CLR) |-> take == !flags.carry)
      else $error("carry branch condition");
   not_neg_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && instr[OPC_HI:OPC_LO] == OP_BR_NOT_NEG) |-> take == !flags.negative)
      else $error("negative branch condition");
   no_ovf_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && instr[OPC_HI:OPC_LO] == OP_BR_NO_OVF) |-> take == !flags.overflow)
      else $error("overflow branch condition");
   nonzero_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && instr[OPC_HI:OPC_LO] == OP_BR_NONZERO) |-> take == !flags.zero)
      else $error("zero branch condition");
   not_taken_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && !take && !is_set) |=> pc == $past(pc) + PC_STEP && state == ST_EXEC)
      else $error("untaken branch not one word");
   always_taken_a: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && state == ST_EXEC && is_long) |-> taken_s)
      else $error("unconditional branch not taken");
   short_ofs_a: assert property (@(posedge ref_clk) disable iff (reset)
      (take && !is_long) |-> $signed(ofs_short) == 2 * $signed(instr[OPC_LO-1:0]))
      else $error("short offset not doubled");
   bank_pick_a: assert property (@(posedge ref_clk) disable iff (reset)
      instr[ACC_POS] |-> file_addr[11:8] == bank_select_register)
      else $error("bank register not used");
   bit_set_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state == ST_WRITE) |-> wr.en && wr.data[set_bit] && flags_out == $past(flags))
      else $error("bit set write wrong");
endmodule

// ### hdl/rbx_file_ram.sv
// File register memory with registered read data
`timescale 1ns/100ps
module rbx_file_ram
   import rbx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data,
   input wire rbx_wr_s wr
);
   // Storage for the whole 4 KB data space
   logic [7:0] mem [0:4095];

   // Write port
   always_ff @(posedge ref_clk)
   begin
      if (wr.en)
      begin
         mem[wr.addr] <= wr.data;
      end
   end

   // Registered read, one cycle of latency
   always_ff @(posedge ref_clk)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule

// ### hdl/rbx_pkg.sv
// Package with opcodes, field positions and carriers for the relative branch unit
package rbx_pkg;
   // Program counter width (21-bit byte address space)
   localparam int PC_W = 21;
   // Upper byte opcodes of conditional branches
   localparam logic [7:0] OP_BR_CARRY_CLR = 8'hE3;
   localparam logic [7:0] OP_BR_NOT_NEG = 8'h7E;
   localparam logic [7:0] OP_BR_NO_OVF = 8'hE5;
   localparam logic [7:0] OP_BR_NONZERO = 8'hE1;
   // Five-bit prefix of the unconditional branch
   localparam logic [4:0] OP_BR_ALWAYS = 5'h1A;
   // Four-bit prefix of the bit-set instruction
   localparam logic [3:0] OP_SET_BIT = 4'h8;
   // Field positions inside a program word
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 8;
   localparam int BIT_HI = 11;
   localparam int BIT_LO = 9;
   localparam int ACC_POS = 8;
   localparam int OFS_BR_W = 11;
   // Access bank split: low addresses hit bank 0, high ones bank 15
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   // Word step of the program counter
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   // Status flags as seen by the branch logic
   typedef struct packed
   {
      logic carry;
      logic negative;
      logic overflow;
      logic zero;
   } rbx_flags_s;
   // Write-back request to the file register memory
   typedef struct packed
   {
      logic en;
      logic [11:0] addr;
      logic [7:0] data;
   } rbx_wr_s;
endpackage

// ### tb/tb_top.sv
// Self-checking bench for the relative branch and bit-set unit
`timescale 1ns/100ps
module tb_top
   import rbx_pkg::*;
;
   logic ref_clk = 1'b0; // 200 MHz clock
   logic reset = 1'b1; // Async reset, high
   logic instr_valid = 1'b0; // Word present
   logic [15:0] instr = 16'h0000; // Program word
   rbx_flags_s flags = 4'h0; // Status flags in
   logic [3:0] bank_select_register = 4'h0; // Bank for access bit set
   logic [PC_W-1:0] pc; // Program counter out
   logic busy; // Second cycle flag
   logic branch_taken; // Taken pulse
   rbx_flags_s flags_out; // Flags seen back
   logic [PC_W-1:0] exp_pc; // Bench copy of the counter
   int n_fail = 0; // Mismatches
   int checks = 0; // Comparisons made

   // Half period of 2.5 ns
   always #2.5 ref_clk = ~ref_clk;

   rbx_core i_dut (
      .ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .flags(flags),
      .bank_select_register(bank_select_register), .pc(pc), .busy(busy), .branch_taken(branch_taken),
      .flags_out(flags_out));

   // Compare one value, counted either way
   task automatic check(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   // One accepted word; a second cycle gets a live word that must be ignored
   task automatic step(input logic [15:0] w, input rbx_flags_s f, input logic tk, input logic bz,
                       input logic [PC_W-1:0] ofs);
      instr = w;
      flags = f;
      instr_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      exp_pc = tk ? exp_pc + PC_STEP + ofs : exp_pc + PC_STEP;
      check("pc", exp_pc, pc);
      check("busy", {20'h00000, bz}, {20'h00000, busy});
      check("branch_taken", {20'h00000, tk}, {20'h00000, branch_taken});
      check("flags_out", {17'h00000, f}, {17'h00000, flags_out});
      if (bz)
      begin
         // Would be a taken branch if the core wrongly accepted it
         instr = 16'hE17F;
         flags = 4'h0;
         @(posedge ref_clk);
         #1;
         check("pc held", exp_pc, pc);
         check("busy end", 21'h000000, {20'h00000, busy});
      end
      // Valid stays up; the next call changes the word in this same step
   endtask

   // Each conditional branch, flag set then clear, at one offset limit, alternating between branches
   task automatic test_cond();
      logic [7:0] opc [4] = '{OP_BR_CARRY_CLR, OP_BR_NOT_NEG, OP_BR_NO_OVF, OP_BR_NONZERO};
      logic [3:0] msk [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
      logic [7:0] n;
      logic [PC_W-1:0] ofs; // Doubled offset, -256 or +254
      for (int i = 0; i < 4; i++)
      begin
         n = i[0] ? 8'h80 : 8'h7F;
         ofs = i[0] ? 21'h1FFF00 : 21'h0000FE;
         step({opc[i], n}, msk[i], 1'b0, 1'b0, 21'h000000);
         step({opc[i], n}, ~msk[i], 1'b1, 1'b1, ofs);
      end
   endtask

   // Unconditional branch at both ends of its offset range
   task automatic test_always();
      step(16'hD3FF, 4'hF, 1'b1, 1'b1, 21'h0007FE);
      step(16'hD400, 4'hF, 1'b1, 1'b1, 21'h1FF800);
   endtask

   // Bit set through both bank choices, flags carried unchanged
   task automatic test_set_bit();
      bank_select_register = 4'h5;
      step(16'h8F25, 4'hA, 1'b0, 1'b1, 21'h000000);
      // Bank register picks bank 5; only the set bit is known, the rest was never written
      check("set bit banked", 21'h000001, {20'h00000, i_dut.u_ram.mem[12'h525][7]});
      bank_select_register = 4'hC;
      step(16'h8070, 4'h5, 1'b0, 1'b1, 21'h000000);
      // Access bit clear, address above the split: bank 15
      check("set bit access high", 21'h000001, {20'h00000, i_dut.u_ram.mem[12'hF70][0]});
      step(16'h8410, 4'h3, 1'b0, 1'b1, 21'h000000);
      // Access bit clear, address below the split: bank 0
      check("set bit access low", 21'h000001, {20'h00000, i_dut.u_ram.mem[12'h010][2]});
      step(16'h0000, 4'h0, 1'b0, 1'b0, 21'h000000);
   endtask

   // Reset in mid-run clears the counter and pulses
   task automatic test_reset();
      reset = 1'b1;
      @(posedge ref_clk);
      #1;
      exp_pc = 21'h000000;
      check("pc reset", exp_pc, pc);
      check("busy reset", 21'h000000, {20'h00000, busy});
      reset = 1'b0;
      step({OP_BR_NONZERO, 8'h01}, 4'h0, 1'b1, 1'b1, 21'h000002);
   endtask

   // Report counts, then the verdict
   task automatic give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      exp_pc = 21'h000000;
      repeat (10) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      test_cond();
      test_always();
      test_set_bit();
      test_reset();
      give_verdict();
   end

   // Watchdog, far beyond the few dozen cycles the run needs
   initial
   begin
      #20000;
      n_fail++;
      give_verdict();
   end
endmodule
